// file: rtl/ext_bus_defs.svh
// Purpose: constants for the external data memory bus interface
// Assumes: 16-bit data space, 8-bit data, one clock at 40 MHz
// Notes:   internal space ends at the configurable boundary below
//
// Functional notes
// [RULE_01] four wait-state settings, one of them zero wait states
// [RULE_02] lower and upper sector with configurable boundary, own wait setting each
// [RULE_03] software picks how many high address pins are used; rest stay ports
// [RULE_04] optional bus keeper on muxed lines, switchable by software
// [RULE_05] when enabled, addresses above internal SRAM reach external pins
// [RULE_06] eight-bit muxed low address/data bus plus separate high address bus
// [RULE_07] when enabled, override direction of every dedicated port pin; unused high pins keep port direction
// [RULE_08] decode each access internal or external; external drives pins
// [RULE_09] valid low address byte on muxed bus when latch strobe falls
// [RULE_10] latch strobe stays low throughout data transfer phase
// [RULE_11] internal accesses may show bus activity but never toggle read/write strobes
// [RULE_12] when disabled, dedicated pins return to normal port values and directions
// [RULE_13] when disabled, addresses above internal SRAM do not alias onto it
// [RULE_14] external operation only while the enable bit is set
// [RULE_15] external byte costs one extra cycle, plus wait states: two, three, four; code adds two, three, four, five cycles over an internal access
// [RULE_16] trailing latch pulse only when next instruction also accesses RAM
// [RULE_17] read floats muxed bus and asserts read strobe; write drives data, write strobe
// [RULE_18] external memory drives read data under read strobe, captures write under write strobe
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH

`define INT_TOP_DEFAULT      16'h21FF
`define HIGH_PINS_FULL       3'h0
`define HIGH_PINS_NONE       3'h7
`define HIGH_ADDR_W          8
`define WAIT_W               2

`endif

// file: rtl/ext_bus_pkg.sv
// Purpose: types for the external data memory bus interface
// Assumes: used with ext_bus_defs.svh
// Notes:   phases of one access
package ext_bus_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WAIT,
        ST_XFER,
        ST_TAIL
    } phase_type;
endpackage : ext_bus_pkg

// file: rtl/external_memory_bus_interface.sv
// Purpose: external data memory bus engine with muxed address/data and latch strobe
// Assumes: CPU offers one access at a time via req_in and waits for done_out
// Notes:   controls are plain ports; internal accesses finish without read/write strobes
`timescale 1ns/1ps
`include "ext_bus_defs.svh"

module external_memory_bus_interface #(
    parameter logic [15:0] INT_TOP = `INT_TOP_DEFAULT
) (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // control bits (no register bus)
    input  wire logic        ext_bus_enable_in,
    input  wire logic [2:0]  sector_limit_in,
    input  wire logic        lower_sector_wait_hi_in,
    input  wire logic        lower_sector_wait_lo_in,
    input  wire logic        upper_sector_wait_hi_in,
    input  wire logic        upper_sector_wait_lo_in,
    input  wire logic        keeper_enable_in,
    input  wire logic [2:0]  high_mask_in,
    // CPU data access
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        next_ram_in,
    output logic             is_external_out,
    output logic             done_out,
    output logic [7:0]       rdata_out,
    // normal port settings for the dedicated pins
    input  wire logic [7:0]  low_port_val_in,
    input  wire logic [7:0]  low_port_dir_in,
    input  wire logic [7:0]  high_port_val_in,
    input  wire logic [7:0]  high_port_dir_in,
    input  wire logic [2:0]  ctl_port_val_in,
    input  wire logic [2:0]  ctl_port_dir_in,
    // pins
    input  wire logic [7:0]  muxed_addr_data_bus_in,
    output logic [7:0]       muxed_addr_data_bus_out,
    output logic [7:0]       muxed_addr_data_bus_oe_out,
    output logic [7:0]       high_addr_bus_out,
    output logic [7:0]       high_addr_bus_oe_out,
    output logic             addr_latch_out,
    output logic             read_n_out,
    output logic             write_n_out,
    output logic [2:0]       ctl_oe_out
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [1:0] wait_count(input logic hi, input logic lo);
        wait_count = {hi, lo};                                      // [RULE_01]
    endfunction : wait_count

    function automatic logic [7:0] high_used(input logic [2:0] m);
        // m=0 all eight pins, m=k releases the top k pins (7 keeps only the lowest pin)
        high_used = 8'hFF >> m;                                      // [RULE_03]
    endfunction : high_used

    logic [15:0] boundary;
    logic        external_hit;
    logic        upper_hit;
    logic [1:0]  sel_wait;

    // 0 means whole external space is upper sector
    assign boundary     = (sector_limit_in == 3'h0) ? INT_TOP + 16'h0001
                          : {1'b0, sector_limit_in, 12'h000};        // [RULE_02]
    assign external_hit = ext_bus_enable_in && (addr_in > INT_TOP);  // [RULE_05] [RULE_13] [RULE_14]
    assign upper_hit    = addr_in >= boundary;
    assign sel_wait     = upper_hit ? wait_count(upper_sector_wait_hi_in, upper_sector_wait_lo_in)
                                    : wait_count(lower_sector_wait_hi_in, lower_sector_wait_lo_in); // [RULE_02]
    assign is_external_out = external_hit;                           // [RULE_08]

    // ****************************************************************
    // access sequencer
    // ****************************************************************
    ext_bus_pkg::phase_type phase_q, phase_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0]  wdata_q, wdata_d;
    logic        we_q, we_d;
    logic        ext_q, ext_d;
    logic        tail_q, tail_d;
    logic [1:0]  wait_q, wait_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [7:0]  keep_q, keep_d;
    logic        done_q, done_d;

    always_comb
    begin
        phase_d = phase_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        we_d    = we_q;
        ext_d   = ext_q;
        tail_d  = tail_q;
        wait_d  = wait_q;
        rdata_d = rdata_q;
        done_d  = 1'b0;
        keep_d  = keep_q;
        unique case (phase_q)
            ext_bus_pkg::ST_IDLE:
            begin
                if (req_in && ext_bus_enable_in)
                begin
                    addr_d  = addr_in;
                    wdata_d = wdata_in;
                    we_d    = we_in;
                    ext_d   = external_hit;                          // [RULE_08]
                    tail_d  = next_ram_in;
                    wait_d  = sel_wait;
                    phase_d = ext_bus_pkg::ST_ADDR;
                end
                else if (req_in)
                begin
                    done_d = 1'b1;
                end
            end
            ext_bus_pkg::ST_ADDR:
            begin
                // internal accesses show address activity but finish here
                if (!ext_q)
                begin
                    done_d  = 1'b1;
                    phase_d = ext_bus_pkg::ST_IDLE;                  // [RULE_11]
                end
                else
                begin
                    phase_d = ext_bus_pkg::ST_WAIT;
                end
            end
            ext_bus_pkg::ST_WAIT:
            begin
                // one base cycle plus one per wait state: 1,2,3,4 cycles in this phase
                if (wait_q == 2'h0)
                begin
                    phase_d = ext_bus_pkg::ST_XFER;                  // [RULE_15]
                end
                else
                begin
                    wait_d = wait_q - 2'h1;
                end
            end
            ext_bus_pkg::ST_XFER:
            begin
                if (!we_q)
                begin
                    rdata_d = muxed_addr_data_bus_in;                // [RULE_18]
                end
                done_d  = 1'b1;
                phase_d = tail_q ? ext_bus_pkg::ST_TAIL : ext_bus_pkg::ST_IDLE;
            end
            ext_bus_pkg::ST_TAIL:
            begin
                phase_d = ext_bus_pkg::ST_IDLE;                      // [RULE_16]
            end
        endcase
        // keeper remembers last driven or sampled value while floating
        if (muxed_addr_data_bus_oe_out != 8'h00)
        begin
            keep_d = muxed_addr_data_bus_out;
        end
        else
        begin
            keep_d = muxed_addr_data_bus_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            phase_q <= ext_bus_pkg::ST_IDLE;
            addr_q  <= 16'h0000;
            wdata_q <= 8'h00;
            we_q    <= 1'b0;
            ext_q   <= 1'b0;
            tail_q  <= 1'b0;
            wait_q  <= 2'h0;
            rdata_q <= 8'h00;
            keep_q  <= 8'h00;
            done_q  <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            we_q    <= we_d;
            ext_q   <= ext_d;
            tail_q  <= tail_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
            keep_q  <= keep_d;
            done_q  <= done_d;
        end
    end

    assign done_out  = done_q;
    assign rdata_out = rdata_q;

    // ****************************************************************
    // pin drive and port override
    // ****************************************************************
    logic       in_addr;
    logic       in_data;
    logic       floating;
    logic [7:0] hmask;

    assign in_addr  = (phase_q == ext_bus_pkg::ST_ADDR);
    assign in_data  = ext_q && ((phase_q == ext_bus_pkg::ST_WAIT) || (phase_q == ext_bus_pkg::ST_XFER));
    assign floating = in_data && !we_q;                              // [RULE_17]
    assign hmask    = high_used(high_mask_in);

    always_comb
    begin
        if (ext_bus_enable_in)
        begin
            // override directions of control pins, muxed pins and used high pins
            ctl_oe_out = 3'h7;                                       // [RULE_07]
            // latch strobe high only in address or trailing phase, low through data
            addr_latch_out = in_addr || (phase_q == ext_bus_pkg::ST_TAIL); // [RULE_09] [RULE_10] [RULE_16]
            read_n_out  = !(in_data && !we_q);                       // [RULE_11] [RULE_17]
            write_n_out = !(in_data && we_q);                        // [RULE_11] [RULE_17]
            if (floating)
            begin
                // keeper holds previous value; without it the pins float
                muxed_addr_data_bus_out    = keep_q;                 // [RULE_04]
                muxed_addr_data_bus_oe_out = keeper_enable_in ? 8'hFF : 8'h00; // [RULE_04]
            end
            else if (in_data)
            begin
                muxed_addr_data_bus_out    = wdata_q;                // [RULE_17]
                muxed_addr_data_bus_oe_out = 8'hFF;
            end
            else
            begin
                muxed_addr_data_bus_out    = addr_q[7:0];            // [RULE_06] [RULE_09]
                muxed_addr_data_bus_oe_out = 8'hFF;                  // [RULE_07]
            end
            // unused high pins stay ordinary port pins
            high_addr_bus_out    = (addr_q[15:8] & hmask) | (high_port_val_in & ~hmask); // [RULE_03] [RULE_06]
            high_addr_bus_oe_out = hmask | (high_port_dir_in & ~hmask);                 // [RULE_03] [RULE_07]
        end
        else
        begin
            ctl_oe_out                 = ctl_port_dir_in;            // [RULE_12]
            addr_latch_out             = ctl_port_val_in[2];
            read_n_out                 = ctl_port_val_in[0];
            write_n_out                = ctl_port_val_in[1];
            muxed_addr_data_bus_out    = low_port_val_in;
            muxed_addr_data_bus_oe_out = low_port_dir_in;
            high_addr_bus_out          = high_port_val_in;
            high_addr_bus_oe_out       = high_port_dir_in;
        end
    end

endmodule : external_memory_bus_interface

// file: sim/ext_sram_model.sv
// Purpose: external byte memory behind a transparent address latch
// Assumes: strobes active low, latch transparent while high
// Notes:   skewed copies avoid races at strobe release
`timescale 1ns/1ps
module ext_sram_model (
    input  wire logic       latch_in,
    input  wire logic       read_n_in,
    input  wire logic       write_n_in,
    input  wire logic [7:0] hi_in,
    input  wire logic [7:0] ad_in,
    output logic      [7:0] drive_out
);
    logic [7:0] mem [0:65535];
    logic [7:0] lo_q;
    logic [7:0] ad_late;
    logic [7:0] hi_late;
    logic       le_late;
    logic       wn_late;
    // latch and write strobes 1 ns late, data 2 ns late: old data still seen at strobe end
    assign #2 ad_late = ad_in;
    assign #2 hi_late = hi_in;
    assign #1 le_late = latch_in;
    assign #1 wn_late = write_n_in;
    always @(le_late or ad_late)
        if (le_late)
            lo_q = ad_late;
    always @(wn_late or ad_late or hi_late or lo_q)
        if (!wn_late)
            mem[{hi_late, lo_q}] = ad_late;
    // released bus shows the inverse so a stale value cannot pass
    assign drive_out = read_n_in ? ~mem[{hi_in, lo_q}] : mem[{hi_in, lo_q}];
endmodule : ext_sram_model

// file: sim/ext_bus_properties.sv
// Purpose: port checks of the external bus engine
// Assumes: bound into every engine instance
// Notes:   W is the wait setting of the sector hit
`timescale 1ns/1ps
module ext_bus_checker #(
    parameter logic [15:0] INT_TOP = 16'h21FF
) (
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic        ext_bus_enable_in,
    input wire logic        keeper_enable_in,
    input wire logic        req_in,
    input wire logic        we_in,
    input wire logic        lower_sector_wait_hi_in,
    input wire logic        lower_sector_wait_lo_in,
    input wire logic        upper_sector_wait_hi_in,
    input wire logic        upper_sector_wait_lo_in,
    input wire logic [2:0]  sector_limit_in,
    input wire logic [2:0]  high_mask_in,
    input wire logic [2:0]  ctl_port_val_in,
    input wire logic [2:0]  ctl_port_dir_in,
    input wire logic [2:0]  ctl_oe_out,
    input wire logic [15:0] addr_in,
    input wire logic [7:0]  wdata_in,
    input wire logic [7:0]  low_port_val_in,
    input wire logic [7:0]  low_port_dir_in,
    input wire logic [7:0]  high_port_val_in,
    input wire logic [7:0]  high_port_dir_in,
    input wire logic [7:0]  muxed_addr_data_bus_out,
    input wire logic [7:0]  muxed_addr_data_bus_oe_out,
    input wire logic [7:0]  high_addr_bus_out,
    input wire logic [7:0]  high_addr_bus_oe_out,
    input wire logic        is_external_out,
    input wire logic        done_out,
    input wire logic        addr_latch_out,
    input wire logic        read_n_out,
    input wire logic        write_n_out
);
    logic [1:0] w_sel;
    logic [7:0] hmask;
    logic       ext_req;
    assign w_sel   = (addr_in[15:12] < {1'b0, sector_limit_in}) ?
                     {lower_sector_wait_hi_in, lower_sector_wait_lo_in} :
                     {upper_sector_wait_hi_in, upper_sector_wait_lo_in};
    assign hmask   = 8'hFF >> high_mask_in;
    assign ext_req = req_in && is_external_out;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    a_addr_phase: assert property (
        ext_req |=> addr_latch_out && muxed_addr_data_bus_oe_out == 8'hFF
        && muxed_addr_data_bus_out == $past(addr_in[7:0])) else $error("no address under latch");
    a_write_data: assert property (
        ext_req && we_in |=> ##1 !write_n_out && read_n_out && muxed_addr_data_bus_oe_out == 8'hFF
        && muxed_addr_data_bus_out == $past(wdata_in, 2)) else $error("write phase wrong");
    a_read_float: assert property (
        ext_req && !we_in |=> ##1 !read_n_out && write_n_out && !addr_latch_out
        && muxed_addr_data_bus_oe_out == {8{keeper_enable_in}}) else $error("read phase wrong");
    a_high_pins: assert property (
        ext_req |=> (high_addr_bus_out & hmask) == ($past(addr_in[15:8]) & hmask)
        && high_addr_bus_oe_out == (hmask | (high_port_dir_in & ~hmask))) else $error("high pins wrong");
    a_wait_zero: assert property (
        ext_req && w_sel == 2'h0 |=> (!done_out) [*3] ##1 done_out) else $error("zero wait timing");
    a_wait_three: assert property (
        ext_req && w_sel == 2'h3 |=> (!done_out) [*6] ##1 done_out) else $error("three wait timing");
    a_int_quiet: assert property (
        req_in && ext_bus_enable_in && !is_external_out |=> (read_n_out && write_n_out && !done_out)
        ##1 (read_n_out && write_n_out && done_out)) else $error("internal access wrong");
    a_off_done: assert property (
        req_in && !ext_bus_enable_in |=> done_out) else $error("disabled access timing");
    a_latch_low: assert property (
        ext_bus_enable_in && (!read_n_out || !write_n_out) |-> !addr_latch_out) else $error("latch in transfer");
    a_decode: assert property (
        is_external_out == (ext_bus_enable_in && addr_in > INT_TOP)) else $error("decode wrong");
    a_port_back: assert property (
        !ext_bus_enable_in |-> muxed_addr_data_bus_oe_out == low_port_dir_in
        && muxed_addr_data_bus_out == low_port_val_in && high_addr_bus_oe_out == high_port_dir_in
        && high_addr_bus_out == high_port_val_in && ctl_oe_out == ctl_port_dir_in
        && {addr_latch_out, write_n_out, read_n_out} == ctl_port_val_in) else $error("port not restored");
    c_ext_read: cover property (ext_req && !we_in);
    c_ext_write: cover property (ext_req && we_in);
    c_int_acc: cover property (req_in && ext_bus_enable_in && !is_external_out);
    c_tail_pulse: cover property (done_out && addr_latch_out);
endmodule : ext_bus_checker
bind external_memory_bus_interface ext_bus_checker #(.INT_TOP(INT_TOP)) checker_i (.*);

// file: sim/external_memory_bus_interface_bench.sv
// Purpose: directed accesses through the external bus engine
// Assumes: memory model on the pins, bench plays the CPU
// Notes:   cycles counted from the request cycle to done
`timescale 1ns/1ps
module external_memory_bus_interface_bench;
    logic        clk_in = 1'b0, resetn_in = 1'b0, ext_bus_enable_in = 1'b0, keeper_enable_in = 1'b0;
    logic        req_in = 1'b0, we_in = 1'b0, next_ram_in = 1'b0;
    logic        lower_sector_wait_hi_in = 1'b0, lower_sector_wait_lo_in = 1'b0;
    logic        upper_sector_wait_hi_in = 1'b0, upper_sector_wait_lo_in = 1'b0;
    logic [2:0]  sector_limit_in = 3'h0, high_mask_in = 3'h0, ctl_port_val_in = 3'h3, ctl_port_dir_in = 3'h0;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0]  wdata_in = 8'h00, low_port_val_in = 8'h5A, low_port_dir_in = 8'h0F;
    logic [7:0]  high_port_val_in = 8'h00, high_port_dir_in = 8'h00, rdata_out, sram_d;
    logic [7:0]  muxed_addr_data_bus_in, muxed_addr_data_bus_out, muxed_addr_data_bus_oe_out;
    logic [7:0]  high_addr_bus_out, high_addr_bus_oe_out;
    logic [2:0]  ctl_oe_out;
    logic        is_external_out, done_out, addr_latch_out, read_n_out, write_n_out;
    int          mismatches = 0;
    int          n_compared = 0;
    always #12.5 clk_in = ~clk_in;
    // memory wins while read strobe is low: the keeper is only weak
    assign muxed_addr_data_bus_in = !read_n_out ? sram_d :
        ((muxed_addr_data_bus_oe_out & muxed_addr_data_bus_out) | (~muxed_addr_data_bus_oe_out & sram_d));
    external_memory_bus_interface dut (.*);
    ext_sram_model mem_i (.latch_in(addr_latch_out), .read_n_in(read_n_out), .write_n_in(write_n_out),
        .hi_in(high_addr_bus_out), .ad_in(muxed_addr_data_bus_in), .drive_out(sram_d));
    task give_verdict;
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task acc(input logic w, input logic [15:0] a, input logic [7:0] d, input int cyc, input logic [7:0] rd);
        int n;
        @(posedge clk_in);
        req_in <= 1'b1; we_in <= w; addr_in <= a; wdata_in <= d;
        @(posedge clk_in);
        req_in <= 1'b0;
        n = 1;
        @(negedge clk_in);
        while (done_out !== 1'b1 && n < 20)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 20)
        begin
            mismatches++;
            give_verdict();
        end
        else
        begin
            check(16'(n), 16'(cyc));
            if (!w && cyc > 2)
                check({8'h00, rdata_out}, {8'h00, rd});
        end
    endtask : acc
    // ********
    // main sequence
    // ********
    initial
    begin
        int k;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(negedge clk_in);
        check({8'h00, muxed_addr_data_bus_oe_out}, 16'h000F);
        acc(1'b0, 16'h8000, 8'h00, 1, 8'h00);
        check({15'h0000, is_external_out}, 16'h0000);
        @(posedge clk_in);
        ext_bus_enable_in <= 1'b1;
        sector_limit_in <= 3'h4;
        for (int w = 0; w < 4; w++)
        begin
            @(posedge clk_in);
            {upper_sector_wait_hi_in, upper_sector_wait_lo_in} <= 2'(w);
            {lower_sector_wait_hi_in, lower_sector_wait_lo_in} <= 2'(3 - w);
            acc(1'b1, 16'h8000 + 16'(w), 8'hA0 + 8'(w), 4 + w, 8'h00);
            acc(1'b1, 16'h3000 + 16'(w), 8'hB0 + 8'(w), 7 - w, 8'h00);
            acc(1'b0, 16'h8000 + 16'(w), 8'h00, 4 + w, 8'hA0 + 8'(w));
            acc(1'b0, 16'h3000 + 16'(w), 8'h00, 7 - w, 8'hB0 + 8'(w));
        end
        acc(1'b0, 16'h0100, 8'h00, 2, 8'h00);
        @(posedge clk_in);
        keeper_enable_in <= 1'b1;
        acc(1'b0, 16'h8001, 8'h00, 7, 8'hA1);
        @(posedge clk_in);
        next_ram_in <= 1'b1;
        acc(1'b0, 16'h3002, 8'h00, 4, 8'hB2);
        // trailing latch pulse already stands in the cycle where done is seen
        k = int'(addr_latch_out);
        repeat (2)
        begin
            @(negedge clk_in);
            k += int'(addr_latch_out);
        end
        check(16'(k), 16'h0001);
        @(posedge clk_in);
        next_ram_in <= 1'b0;
        high_mask_in <= 3'h2;
        @(negedge clk_in);
        check({8'h00, high_addr_bus_oe_out}, 16'h003F);
        @(posedge clk_in);
        ext_bus_enable_in <= 1'b0;
        @(negedge clk_in);
        check({8'h00, muxed_addr_data_bus_out}, 16'h005A);
        give_verdict();
    end
endmodule : external_memory_bus_interface_bench
